/* File: include/uirc_pkg.sv */
// Package for the infrared pulse codec: offsets, fields, reset values.
// Assumes a 32-bit AXI4-Lite register bus and one 200 MHz clock.
package uirc_pkg;
   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] UIRC_OFS_MODE = 8'h00;
   localparam logic [7:0] UIRC_OFS_STAT = 8'h04;
   localparam logic [7:0] UIRC_OFS_TXH = 8'h08;
   localparam logic [7:0] UIRC_OFS_RXH = 8'h0C;
   localparam logic [7:0] UIRC_OFS_BAUD = 8'h10;
   // ==========================================================
   // Field positions
   localparam int UIRC_BIT_PORT_EN = 15;
   localparam int UIRC_BIT_IR_EN = 12;
   localparam int UIRC_BIT_PINSEL_LO = 8;
   localparam int UIRC_BIT_TX_POL = 14;
   localparam logic [1:0] UIRC_PINSEL_BCLK = 2'h3;
   // ==========================================================
   // Reset values
   localparam logic [15:0] UIRC_MODE_RST = 16'h0000;
   localparam logic [15:0] UIRC_STAT_RST = 16'h0110;
   localparam logic [15:0] UIRC_BAUD_RST = 16'h0000;
   // ==========================================================
   // Encoder and decoder timing, in 16x ticks
   localparam logic [3:0] UIRC_ENC_HI_START = 4'h7;
   localparam logic [3:0] UIRC_ENC_HI_END = 4'hA;
   localparam logic [3:0] UIRC_DEC_LAST = 4'hF;
   // AXI answers
   localparam logic [1:0] UIRC_RESP_OKAY = 2'h0;
   localparam logic [1:0] UIRC_RESP_SLVERR = 2'h2;
endpackage : uirc_pkg

/* File: hdl/uirc_skid.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module uirc_skid
   import uirc_pkg::*;
#(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [WIDTH-1:0] in_data,
   input wire logic in_valid,
   output logic in_ready,
   output logic [WIDTH-1:0] out_data,
   output logic out_valid,
   input wire logic out_ready
);
   if (WIDTH < 1) begin : g_width_check
      $error("uirc_skid: WIDTH must be positive");
   end
   logic [WIDTH-1:0] mem_reg [2];
   logic wp_reg, rp_reg;
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   logic in_ready_reg;
   wire logic push = in_valid && in_ready_reg;
   wire logic pop = out_valid && out_ready;
   assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};
   // Ready from a flop, equal to count below two
   assign in_ready = in_ready_reg;
   assign out_valid = (cnt_reg != 2'h0);
   assign out_data = mem_reg[rp_reg];
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wp_reg] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         wp_reg <= 1'b0;
         rp_reg <= 1'b0;
         cnt_reg <= 2'h0;
         in_ready_reg <= 1'b0;
      end else begin
         if (push) wp_reg <= ~wp_reg;
         if (pop) rp_reg <= ~rp_reg;
         cnt_reg <= cnt_next;
         in_ready_reg <= (cnt_next != 2'h2);
      end
   end
endmodule // uirc_skid

/* File: hdl/uirc_decoder.sv */
// Infrared pulse decoder: falling edges give 16-tick low windows.
// Assumes a synchronised input and a one-cycle 16x tick on one clock.
`timescale 1ns/10ps
module uirc_decoder
   import uirc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic enable,
   input wire logic tick,
   input wire logic rx_sync,
   output logic dec_out
);
   logic prev_reg, low_reg, again_reg;
   logic [3:0] cnt_reg;
   wire logic fall = tick && prev_reg && !rx_sync;
   always_ff @(posedge clk) begin
      if (!rst_b || !enable) prev_reg <= 1'b1;
      else if (tick) prev_reg <= rx_sync;
   end
   always_ff @(posedge clk) begin
      if (!rst_b || !enable) begin
         low_reg <= 1'b0;
         again_reg <= 1'b0;
         cnt_reg <= 4'h0;
      end else if (tick) begin
         if (!low_reg) begin
            if (fall) begin
               low_reg <= 1'b1;
               cnt_reg <= 4'h0;
            end
         end else if (cnt_reg == UIRC_DEC_LAST) begin
            cnt_reg <= 4'h0;
            low_reg <= again_reg || fall;
            again_reg <= 1'b0;
         end else begin
            cnt_reg <= cnt_reg + 4'h1;
            if (fall) again_reg <= 1'b1;
         end
      end
   end
   assign dec_out = !low_reg;
endmodule // uirc_decoder

/* File: hdl/uirc_codec.sv */
// Top of the infrared pulse codec with its AXI4-Lite register file.
// Assumes serial bits arrive on a valid/ready stream from the port core.
// What this block does
// - Drive 16x clock out when port enabled and select is 11
// - Codec active only while enable bit set
// - Codec uses rx and tx pins
// - One bit: all sixteen ticks low
// - Zero bit: 7 low, 3 high, 6 low
// - Polarity affects only infrared transmit
// - Idle level follows polarity bit
// - Falling edge gives sixteen-tick low
// - Extra edge extends low by sixteen
// - Decoded lag seven to eight ticks
// - Inverted input decodes, lag ten-eleven
// - Short glitches left to majority sampling
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module uirc_codec
   import uirc_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RST_B,
   input wire logic [7:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [31:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [7:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [31:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic TX_BIT_DATA,
   input wire logic TX_BIT_VALID,
   output logic TX_BIT_READY,
   input wire logic TX_RAW,
   output logic RX_DECODED,
   input wire logic SERIAL_RX_PIN,
   output logic SERIAL_TX_PIN,
   output logic BAUD_CLOCK_OUT_PIN,
   output logic BAUD_CLOCK_OUT_OE
);
   // ==========================================================
   // Registers
   logic [15:0] mode_reg, stat_reg, baud_reg, txh_reg;
   logic [15:0] rxh_reg;
   wire logic port_en = mode_reg[UIRC_BIT_PORT_EN];
   wire logic ir_en = port_en && mode_reg[UIRC_BIT_IR_EN];
   wire logic tx_pol = stat_reg[UIRC_BIT_TX_POL];
   wire logic [1:0] pin_sel = mode_reg[UIRC_BIT_PINSEL_LO +: 2];

   // ==========================================================
   // AXI4-Lite write side
   logic aw_hold_reg, w_hold_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic awready_reg, wready_reg, bvalid_reg;
   logic [1:0] bresp_reg;
   wire logic aw_take = S_AXI_AWVALID && awready_reg;
   wire logic w_take = S_AXI_WVALID && wready_reg;
   wire logic wr_go = aw_hold_reg && w_hold_reg && !bvalid_reg;

   function automatic logic addr_ok(input logic [7:0] a);
      addr_ok = (a == UIRC_OFS_MODE) || (a == UIRC_OFS_STAT) ||
                (a == UIRC_OFS_TXH) || (a == UIRC_OFS_RXH) ||
                (a == UIRC_OFS_BAUD);
   endfunction

   function automatic logic [15:0] merge(input logic [15:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] s);
      merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg <= 32'h0000_0000;
         w_strb_reg <= 4'h0;
         awready_reg <= 1'b0;
         wready_reg <= 1'b0;
         bvalid_reg <= 1'b0;
         bresp_reg <= UIRC_RESP_OKAY;
      end else begin
         awready_reg <= !aw_hold_reg && !aw_take;
         wready_reg <= !w_hold_reg && !w_take;
         if (aw_take) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= S_AXI_AWADDR;
         end
         if (w_take) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= S_AXI_WDATA;
            w_strb_reg <= S_AXI_WSTRB;
         end
         if (wr_go) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid_reg <= 1'b1;
            bresp_reg <= addr_ok(aw_addr_reg) ? UIRC_RESP_OKAY
                                              : UIRC_RESP_SLVERR;
         end else if (bvalid_reg && S_AXI_BREADY) begin
            bvalid_reg <= 1'b0;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         mode_reg <= UIRC_MODE_RST;
         stat_reg <= UIRC_STAT_RST;
         baud_reg <= UIRC_BAUD_RST;
         txh_reg <= 16'h0000;
      end else if (wr_go) begin
         case (aw_addr_reg)
            UIRC_OFS_MODE: mode_reg <= merge(mode_reg, w_data_reg, w_strb_reg);
            UIRC_OFS_STAT: stat_reg <= merge(stat_reg, w_data_reg, w_strb_reg);
            UIRC_OFS_TXH: txh_reg <= merge(txh_reg, w_data_reg, w_strb_reg);
            UIRC_OFS_BAUD: baud_reg <= merge(baud_reg, w_data_reg, w_strb_reg);
            default: ;
         endcase
      end
   end

   // ==========================================================
   // AXI4-Lite read side
   logic arready_reg, rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0] rresp_reg;
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         arready_reg <= 1'b0;
         rvalid_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         rresp_reg <= UIRC_RESP_OKAY;
      end else begin
         arready_reg <= !rvalid_reg && !(S_AXI_ARVALID && arready_reg);
         if (S_AXI_ARVALID && arready_reg) begin
            rvalid_reg <= 1'b1;
            rresp_reg <= addr_ok(S_AXI_ARADDR) ? UIRC_RESP_OKAY
                                               : UIRC_RESP_SLVERR;
            case (S_AXI_ARADDR)
               UIRC_OFS_MODE: rdata_reg <= {16'h0000, mode_reg};
               UIRC_OFS_STAT: rdata_reg <= {16'h0000, stat_reg};
               UIRC_OFS_RXH: rdata_reg <= {16'h0000, rxh_reg};
               UIRC_OFS_BAUD: rdata_reg <= {16'h0000, baud_reg};
               default: rdata_reg <= 32'h0000_0000;
            endcase
         end else if (rvalid_reg && S_AXI_RREADY) begin
            rvalid_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // 16x tick from baud divisor
   logic [15:0] div_reg;
   logic tick_reg, bclk_reg;
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B || !port_en) begin
         div_reg <= 16'h0000;
         tick_reg <= 1'b0;
         bclk_reg <= 1'b0;
      end else if (div_reg >= baud_reg) begin
         div_reg <= 16'h0000;
         tick_reg <= 1'b1;
         bclk_reg <= 1'b1;
      end else begin
         div_reg <= div_reg + 16'h0001;
         tick_reg <= 1'b0;
         bclk_reg <= (div_reg < (baud_reg >> 1));
      end
   end

   // ==========================================================
   // Receive pin synchroniser and decoder
   logic [2:0] rx_sy_reg;
   logic rx_stable_reg;
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         rx_sy_reg <= 3'b111;
         rx_stable_reg <= 1'b1;
      end else begin
         rx_sy_reg <= {rx_sy_reg[1:0], SERIAL_RX_PIN};
         if (rx_sy_reg[2] == rx_sy_reg[1]) rx_stable_reg <= rx_sy_reg[1];
      end
   end

   logic dec_out;
   uirc_decoder u_dec (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .enable(ir_en),
      .tick(tick_reg),
      .rx_sync(rx_stable_reg),
      .dec_out(dec_out)
   );

   logic rx_out_reg;
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         rx_out_reg <= 1'b1;
         rxh_reg <= 16'h0000;
      end else begin
         rx_out_reg <= ir_en ? dec_out : rx_stable_reg;
         rxh_reg <= {15'h0000, rx_out_reg};
      end
   end

   // ==========================================================
   // Transmit bit buffer and encoder
   logic buf_valid, buf_data, pop;
   uirc_skid #(.WIDTH(1)) u_buf (
      .clk(SYS_CLK),
      .rst_b(RST_B),
      .in_data(TX_BIT_DATA),
      .in_valid(TX_BIT_VALID),
      .in_ready(TX_BIT_READY),
      .out_data(buf_data),
      .out_valid(buf_valid),
      .out_ready(pop)
   );

   logic busy_reg, bit_reg;
   logic [3:0] ph_reg;
   assign pop = ir_en && tick_reg && (!busy_reg || ph_reg == 4'hF);
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B || !ir_en) begin
         busy_reg <= 1'b0;
         bit_reg <= 1'b1;
         ph_reg <= 4'h0;
      end else if (tick_reg) begin
         if (pop && buf_valid) begin
            busy_reg <= 1'b1;
            bit_reg <= buf_data;
            ph_reg <= 4'h0;
         end else if (busy_reg && ph_reg == 4'hF) begin
            busy_reg <= 1'b0;
         end else if (busy_reg) begin
            ph_reg <= ph_reg + 4'h1;
         end
      end
   end

   // Pulse in ticks 7 to 9 for zero
   wire logic pulse = busy_reg && !bit_reg &&
      ph_reg >= UIRC_ENC_HI_START && ph_reg < UIRC_ENC_HI_END;

   logic tx_reg, bout_reg, boe_reg;
   always_ff @(posedge SYS_CLK) begin
      if (!RST_B) begin
         tx_reg <= 1'b1;
         bout_reg <= 1'b0;
         boe_reg <= 1'b0;
      end else begin
         if (ir_en) tx_reg <= pulse ^ tx_pol;
         else tx_reg <= TX_RAW;
         boe_reg <= port_en && (pin_sel == UIRC_PINSEL_BCLK);
         bout_reg <= port_en && (pin_sel == UIRC_PINSEL_BCLK) && bclk_reg;
      end
   end

   assign S_AXI_AWREADY = awready_reg;
   assign S_AXI_WREADY = wready_reg;
   assign S_AXI_BVALID = bvalid_reg;
   assign S_AXI_BRESP = bresp_reg;
   assign S_AXI_ARREADY = arready_reg;
   assign S_AXI_RVALID = rvalid_reg;
   assign S_AXI_RDATA = rdata_reg;
   assign S_AXI_RRESP = rresp_reg;
   assign SERIAL_TX_PIN = tx_reg;
   assign RX_DECODED = rx_out_reg;
   assign BAUD_CLOCK_OUT_PIN = bout_reg;
   assign BAUD_CLOCK_OUT_OE = boe_reg;

   // ==========================================================
   // Checks
   // Idle level
   property p_idle;
      @(posedge SYS_CLK) disable iff (!RST_B)
      ($past(ir_en) && ir_en && !$past(busy_reg)) |-> tx_reg == $past(tx_pol);
   endproperty
   a_idle: assert property (p_idle) else $error("tx idle level wrong");
   property p_bclk_off;
      @(posedge SYS_CLK) disable iff (!RST_B)
      !$past(port_en) |-> !BAUD_CLOCK_OUT_OE;
   endproperty
   a_bclk_off: assert property (p_bclk_off) else $error("bclk enabled");
   property p_one_bit;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (ir_en && busy_reg && bit_reg) |=> !ir_en || tx_reg == $past(tx_pol);
   endproperty
   a_one_bit: assert property (p_one_bit) else $error("one bit pulsed");
   property p_zero_bit;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (ir_en && busy_reg && !bit_reg && ph_reg == 4'h8) |=>
         !ir_en || tx_reg != $past(tx_pol);
   endproperty
   a_zero_bit: assert property (p_zero_bit) else $error("no pulse");
   property p_raw;
      @(posedge SYS_CLK) disable iff (!RST_B)
      !ir_en |=> tx_reg == $past(TX_RAW);
   endproperty
   a_raw: assert property (p_raw) else $error("raw tx wrong");
   property p_dec_low;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (ir_en && u_dec.fall && dec_out) |=> !ir_en || !dec_out;
   endproperty
   a_dec_low: assert property (p_dec_low) else $error("no low");
   property p_rx_sel;
      @(posedge SYS_CLK) disable iff (!RST_B)
      ir_en |=> rx_out_reg == $past(dec_out);
   endproperty
   a_rx_sel: assert property (p_rx_sel) else $error("rx path wrong");
   property p_dec_off;
      @(posedge SYS_CLK) disable iff (!RST_B)
      !ir_en |=> dec_out;
   endproperty
   a_dec_off: assert property (p_dec_off) else $error("dec active");
   property p_dec_again;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (ir_en && tick_reg && u_dec.low_reg && u_dec.again_reg &&
         u_dec.cnt_reg == UIRC_DEC_LAST) |=> !dec_out;
   endproperty
   a_dec_again: assert property (p_dec_again) else $error("no extend");
   property p_dec_tick;
      @(posedge SYS_CLK) disable iff (!RST_B)
      (ir_en && !tick_reg) |=> $stable(u_dec.cnt_reg);
   endproperty
   a_dec_tick: assert property (p_dec_tick) else $error("off tick");
   c_zero: cover property (@(posedge SYS_CLK) pulse);
   c_ext: cover property (@(posedge SYS_CLK) u_dec.again_reg);
   c_bclk: cover property (@(posedge SYS_CLK) BAUD_CLOCK_OUT_PIN);
endmodule // uirc_codec

/* File: test/uirc_ir_xcvr.sv */
// Infrared transceiver model at the far side of the codec pins.
// Assumes one clock; receive pulses are timed in clock cycles.
`timescale 1ns/10ps
module uirc_ir_xcvr (
   input wire logic clk,
   input wire logic tx_pin,
   output logic rx_pin
);
   int tx_hi = 0;
   int tx_lo = 0;
   logic idle_lvl = 1'h1;
   initial rx_pin = 1'h1;
   // ==========================================================
   // Emitter light, counted per clock
   always @(posedge clk) begin
      if (tx_pin === 1'h1)
         tx_hi <= tx_hi + 1;
      else
         tx_lo <= tx_lo + 1;
   end
   // ==========================================================
   // Detector line: idle level and pulses
   task automatic set_idle(input logic lvl);
      @(posedge clk);
      idle_lvl <= lvl;
      rx_pin <= lvl;
   endtask
   task automatic pulse(input int width);
      @(posedge clk);
      rx_pin <= ~idle_lvl;
      repeat (width) @(posedge clk);
      rx_pin <= idle_lvl;
   endtask
endmodule // uirc_ir_xcvr

/* File: test/tb.sv */
// Self-checking bench for the infrared pulse codec.
// Assumes the codec top, its package and the transceiver model.
`timescale 1ns/10ps
module tb
   import uirc_pkg::*;
;
   logic sys_clk = 1'h0;
   logic rst_b = 1'h0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic [3:0] wstrb = 4'hF;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
   logic arvalid = 1'h0, rready = 1'h0;
   logic tx_data = 1'h0, tx_valid = 1'h0, tx_raw = 1'h0, bclk_q = 1'h0;
   logic awready, wready, bvalid, arready, rvalid, bit_ready;
   logic rx_dec, rx_pin, tx_pin, bclk, bclk_oe;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int mismatches = 0, num_checks = 0;
   int dec_lo = 0, bclk_rise = 0, stall_cnt = 0;

   always #2.5 sys_clk = ~sys_clk;

   uirc_codec u_uirc_codec (.SYS_CLK(sys_clk), .RST_B(rst_b),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
      .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .TX_BIT_DATA(tx_data), .TX_BIT_VALID(tx_valid),
      .TX_BIT_READY(bit_ready), .TX_RAW(tx_raw), .RX_DECODED(rx_dec),
      .SERIAL_RX_PIN(rx_pin), .SERIAL_TX_PIN(tx_pin),
      .BAUD_CLOCK_OUT_PIN(bclk), .BAUD_CLOCK_OUT_OE(bclk_oe));

   uirc_ir_xcvr u_ir_xcvr (.clk(sys_clk), .tx_pin(tx_pin),
      .rx_pin(rx_pin));

   // ==========================================================
   // Observers
   always @(posedge sys_clk) begin
      dec_lo <= dec_lo + int'(rx_dec === 1'h0);
      bclk_q <= bclk;
      if (bclk === 1'h1 && bclk_q === 1'h0) begin
         bclk_rise <= bclk_rise + 1;
      end
      if (tx_valid === 1'h1 && bit_ready !== 1'h1) begin
         stall_cnt <= stall_cnt + 1;
      end
   end

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want) begin
         mismatches++;
         $display("mismatch at %0t: got %h want %h", $time, seen, want);
      end
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (awready === 1'h1) begin
            awvalid <= 1'h0;
         end
         if (wready === 1'h1) begin
            wvalid <= 1'h0;
         end
      end while (bvalid !== 1'h1);
      bready <= 1'h0;
      @(posedge sys_clk);
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
                           output logic [1:0] r);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (arready === 1'h1) begin
            arvalid <= 1'h0;
         end
      end while (rvalid !== 1'h1);
      d = rdata;
      r = rresp;
      rready <= 1'h0;
      @(posedge sys_clk);
   endtask

   task automatic send_bits(input logic [3:0] bits, input int cnt);
      for (int i = 0; i < cnt; i++) begin
         tx_data <= bits[i];
         tx_valid <= 1'h1;
         do begin
            @(posedge sys_clk);
         end while (bit_ready !== 1'h1);
      end
      tx_valid <= 1'h0;
   endtask

   // ==========================================================
   // Scenarios
   task automatic test_regs();
      logic [31:0] d;
      logic [1:0] r;
      axi_read(UIRC_OFS_MODE, d, r);
      check(d, 32'h0000_0000);
      check({30'h0, r}, {30'h0, UIRC_RESP_OKAY});
      axi_read(UIRC_OFS_STAT, d, r);
      check(d, 32'h0000_0110);
      axi_read(UIRC_OFS_BAUD, d, r);
      check(d, 32'h0000_0000);
      axi_read(UIRC_OFS_TXH, d, r);
      check(d, 32'h0000_0000);
      axi_read(8'h14, d, r);
      check({30'h0, r}, {30'h0, UIRC_RESP_SLVERR});
      check(d, 32'h0000_0000);
      axi_write(UIRC_OFS_BAUD, 32'h0000_0001);
      axi_read(UIRC_OFS_BAUD, d, r);
      check(d, 32'h0000_0001);
      // Upper lane strobed off must stay untouched
      wstrb <= 4'h1;
      axi_write(UIRC_OFS_BAUD, 32'h0000_FF01);
      wstrb <= 4'hF;
      axi_read(UIRC_OFS_BAUD, d, r);
      check(d, 32'h0000_0001);
      axi_read(UIRC_OFS_RXH, d, r);
      check(d, 32'h0000_0001);
   endtask

   task automatic test_bclk();
      int r0;
      axi_write(UIRC_OFS_MODE, 32'h0000_8300);
      repeat (4) @(posedge sys_clk);
      check({31'h0, bclk_oe}, 32'h0000_0001);
      r0 = bclk_rise;
      repeat (64) @(posedge sys_clk);
      check(bclk_rise - r0, 32'h0000_0020);
      axi_write(UIRC_OFS_MODE, 32'h0000_0300);
      repeat (4) @(posedge sys_clk);
      check({31'h0, bclk_oe}, 32'h0000_0000);
   endtask

   task automatic test_encode();
      int h0, s0;
      axi_write(UIRC_OFS_STAT, 32'h0000_0000);
      axi_write(UIRC_OFS_MODE, 32'h0000_9000);
      repeat (40) @(posedge sys_clk);
      check({31'h0, tx_pin}, 32'h0000_0000);
      h0 = u_ir_xcvr.tx_hi;
      s0 = stall_cnt;
      send_bits(4'hA, 4);
      repeat (100) @(posedge sys_clk);
      check(u_ir_xcvr.tx_hi - h0, 32'h0000_000C);
      check({31'h0, stall_cnt > s0}, 32'h0000_0001);
      axi_write(UIRC_OFS_STAT, 32'h0000_4000);
      repeat (40) @(posedge sys_clk);
      check({31'h0, tx_pin}, 32'h0000_0001);
      h0 = u_ir_xcvr.tx_lo;
      send_bits(4'h2, 2);
      repeat (100) @(posedge sys_clk);
      check(u_ir_xcvr.tx_lo - h0, 32'h0000_0006);
      axi_write(UIRC_OFS_MODE, 32'h0000_8000);
      tx_raw <= 1'h0;
      repeat (8) @(posedge sys_clk);
      check({31'h0, tx_pin}, 32'h0000_0000);
      tx_raw <= 1'h1;
      repeat (8) @(posedge sys_clk);
      check({31'h0, tx_pin}, 32'h0000_0001);
   endtask

   task automatic test_decode();
      int d0;
      axi_write(UIRC_OFS_STAT, 32'h0000_0000);
      axi_write(UIRC_OFS_MODE, 32'h0000_9000);
      u_ir_xcvr.set_idle(1'h0);
      repeat (80) @(posedge sys_clk);
      d0 = dec_lo;
      u_ir_xcvr.pulse(6);
      repeat (100) @(posedge sys_clk);
      check(dec_lo - d0, 32'h0000_0020);
      d0 = dec_lo;
      u_ir_xcvr.pulse(6);
      repeat (14) @(posedge sys_clk);
      u_ir_xcvr.pulse(6);
      repeat (120) @(posedge sys_clk);
      check(dec_lo - d0, 32'h0000_0040);
      u_ir_xcvr.set_idle(1'h1);
      repeat (80) @(posedge sys_clk);
      d0 = dec_lo;
      u_ir_xcvr.pulse(6);
      repeat (100) @(posedge sys_clk);
      check(dec_lo - d0, 32'h0000_0020);
      axi_write(UIRC_OFS_MODE, 32'h0000_8000);
      repeat (20) @(posedge sys_clk);
      d0 = dec_lo;
      u_ir_xcvr.pulse(6);
      repeat (20) @(posedge sys_clk);
      check(dec_lo - d0, 32'h0000_0006);
   endtask

   task automatic test_reset();
      logic [31:0] d;
      logic [1:0] r;
      rst_b <= 1'h0;
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'h1;
      @(posedge sys_clk);
      check({31'h0, tx_pin}, 32'h0000_0001);
      check({31'h0, bclk_oe}, 32'h0000_0000);
      axi_read(UIRC_OFS_MODE, d, r);
      check(d, {16'h0000, UIRC_MODE_RST});
      axi_read(UIRC_OFS_STAT, d, r);
      check(d, {16'h0000, UIRC_STAT_RST});
   endtask

   // ==========================================================
   // Verdict
   task automatic complete_run();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      mismatches++;
      complete_run();
   end

   initial begin
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'h1;
      @(posedge sys_clk);
      test_regs();
      test_bclk();
      test_encode();
      test_decode();
      test_reset();
      complete_run();
   end
endmodule // tb
